// ==== design/pg_pkg.sv ====
/*
  constants, types and helpers shared by the gpio port block.
  assumes a 125 MHz core clock and a 32-bit apb register bus.
*/
package pg_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int PG_NPIN = 5;
  localparam int PG_NREG = 8;

  // ---------------------------------------------------------------
  // register byte offsets (pin x config at PG_OFS_CFG0 + 4*x)
  // ---------------------------------------------------------------
  localparam logic [11:0] PG_OFS_CFG0   = 12'h000;
  localparam logic [11:0] PG_OFS_CTRL   = 12'h014;
  localparam logic [11:0] PG_OFS_ENSRC  = 12'h018;
  localparam logic [11:0] PG_OFS_VSSRC  = 12'h01C;
  localparam logic [11:0] PG_OFS_REGBIT = 12'h020;
  localparam logic [11:0] PG_OFS_EVENT  = 12'h024;
  localparam logic [11:0] PG_OFS_STATUS = 12'h028;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int PG_CF_FUNC = 0;
  localparam int PG_CF_POL  = 2;
  localparam int PG_CF_MODE = 3;
  localparam int PG_CF_WEN  = 4;
  localparam int PG_CF_WSTY = 5;
  localparam int PG_CF_PULL = 6;
  localparam int PG_CF_OSRC = 8;
  localparam int PG_CT_DEB  = 0;
  localparam int PG_CT_QOFF = 4;
  localparam int PG_CT_CKON = 5;
  localparam int PG_CT_PAUS = 6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [10:0] PG_CFG_RST  = 11'h000;
  localparam logic [6:0]  PG_CTRL_RST = 7'h00;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] PG_FN_ALT = 2'h0;
  localparam logic [1:0] PG_FN_GPI = 2'h1;
  localparam logic [1:0] PG_FN_OD  = 2'h2;
  localparam logic [1:0] PG_FN_PP  = 2'h3;
  localparam logic [2:0] PG_OS_MODE  = 3'h0;
  localparam logic [2:0] PG_OS_SEQ   = 3'h1;
  localparam logic [2:0] PG_OS_CLK   = 3'h2;
  localparam logic [2:0] PG_OS_FAULT = 3'h3;

  typedef enum logic [1:0] {
    PG_PM_QUIESC = 2'b00,
    PG_PM_ACTIVE = 2'b01,
    PG_PM_OFF    = 2'b11,
    PG_PM_RESET  = 2'b10
  } pg_pmode_t;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int PG_CLK_MHZ   = 125;
  localparam int PG_FAULT_MS  = 100;
  localparam int PG_FAULT_CYC = PG_FAULT_MS * 1000 * PG_CLK_MHZ;
  localparam int PG_TICK_MS   = 1;
  localparam int PG_TICK_CYC  = PG_TICK_MS * 1000 * PG_CLK_MHZ;
  // cycles after reset before pin edges count: two sync flops, filter, edge flop
  localparam logic [2:0] PG_ARM_CYC = 3'h4;

  // debounce time in millisecond ticks per setting
  function automatic logic [3:0] pg_deb_ticks(input logic [1:0] sel);
    case (sel)
      2'h0:    return 4'h1;
      2'h1:    return 4'h2;
      2'h2:    return 4'h5;
      default: return 4'hA;
    endcase
  endfunction : pg_deb_ticks

  // source code 0 = none, 1..3 = pin of that number
  function automatic logic pg_pick(input logic [1:0] s, input logic [4:0] e);
    return (s != 2'h0) && e[s];
  endfunction : pg_pick

endpackage : pg_pkg

// ==== design/pg_filter.sv ====
/*
  one pin input: two-stage synchroniser and optional debounce.
  assumes a one-cycle millisecond tick from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pg_filter
  import pg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       pin,
  input  wire logic       deb_on,
  input  wire logic       tick,
  input  wire logic [3:0] limit,
  output logic            lvl
);
  logic       s1_q;
  logic       s2_q;
  logic       lvl_q;
  logic [3:0] cnt_q;

  // ---------------------------------------------------------------
  // sync and filter
  // ---------------------------------------------------------------
  wire differ = s2_q ^ lvl_q;
  wire done   = tick && (cnt_q + 4'h1 >= limit);

  // level must stay changed for the whole debounce time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q  <= 1'b0;
      s2_q  <= 1'b0;
      lvl_q <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      s1_q  <= pin;
      s2_q  <= s1_q;
      if (!deb_on || (differ && done)) lvl_q <= s2_q;
      if (!differ || !deb_on) cnt_q <= 4'h0;
      else if (tick) cnt_q <= cnt_q + 4'h1;
    end
  end

  assign lvl = lvl_q;
endmodule : pg_filter
`default_nettype wire

// ==== design/pg_top.sv ====
/*
  five-pin gpio port of a power management device with apb registers.
  assumes apb master on MCLK, power mode and sequencer from same clock,
  pins, supply comparator and 32 kHz clock arriving asynchronously.
*/
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pg_top
  import pg_pkg::*;
#(
  parameter int unsigned FAULT_CYCLES = PG_FAULT_CYC,
  parameter int unsigned TICK_CYCLES  = PG_TICK_CYC
) (
  input  wire logic        MCLK,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic [4:0]  GPIO_IN,
  output logic      [4:0]  GPIO_OUT,
  output logic      [4:0]  GPIO_OE,
  output logic      [4:0]  GPIO_PU,
  output logic      [4:0]  GPIO_PD,
  input  wire logic [1:0]  PWR_MODE,
  input  wire logic        SLOW_CLK_IN,
  input  wire logic        VSYS_LOW,
  input  wire logic        SEQ_CLK_EN,
  input  wire logic [4:0]  SEQ_OUT,
  input  wire logic        SEQ_WR,
  input  wire logic [7:0]  SEQ_REG_EN,
  input  wire logic [7:0]  SEQ_REG_AB,
  output logic      [7:0]  REG_EN,
  output logic      [7:0]  REG_AB,
  output logic             SYSTEM_ENABLE_INPUT_BIT,
  output logic             POWER_ENABLE_INPUT_BIT,
  output logic             PWRDOWN_REQ,
  output logic             WAKEUP_REQ,
  output logic             WDOG_CLR,
  output logic             WDOG_HOLD,
  output logic             WAIT_EDGE,
  output logic             EVENT_PEND
);
  logic [10:0] cfg_q [PG_NPIN];
  logic [6:0]  ctrl_q;
  logic [15:0] ensrc_q;
  logic [15:0] vssrc_q;
  logic [7:0]  en_q, en_d, ab_q, ab_d;
  logic [4:0]  ev_q, act_q;
  logic        rdy_q, err_q, sys_q, pwr_q;
  logic [31:0] rd_q;
  logic        pd_q, wk_q, kclr_q, khold_q, wait_q, pend_q;
  logic [4:0]  out_q, oe_q, pu_q, pd5_q;
  logic        v1_q, v2_q, c1_q, c2_q, flt_q;
  logic [23:0] fcnt_q;
  logic [16:0] tcnt_q;
  logic [2:0]  arm_q;

  // ---------------------------------------------------------------
  // apb slave: one wait state, registered read data
  // ---------------------------------------------------------------
  wire        acc   = PSEL && PENABLE;
  wire        first = acc && !rdy_q;
  wire        wr    = acc && rdy_q && PWRITE;
  wire [11:0] a     = PADDR;
  wire        a_cfg = (a[11:2] < 10'(PG_NPIN)) && (a[1:0] == 2'h0);
  wire [2:0]  a_idx = a[4:2];
  wire        hit   = a_cfg || a == PG_OFS_CTRL || a == PG_OFS_ENSRC
                      || a == PG_OFS_VSSRC || a == PG_OFS_REGBIT
                      || a == PG_OFS_EVENT || a == PG_OFS_STATUS;
  wire [4:0]  lvl;
  wire [31:0] stat_w = {24'h00_0000, khold_q, pwr_q, sys_q, act_q};
  wire [31:0] rdat =
    a_cfg                ? {21'h00_0000, cfg_q[a_idx]} :
    a == PG_OFS_CTRL     ? {25'h000_0000, ctrl_q} :
    a == PG_OFS_ENSRC    ? {16'h0000, ensrc_q} :
    a == PG_OFS_VSSRC    ? {16'h0000, vssrc_q} :
    a == PG_OFS_REGBIT   ? {16'h0000, ab_q, en_q} :
    a == PG_OFS_EVENT    ? {27'h000_0000, ev_q} :
    a == PG_OFS_STATUS   ? stat_w : 32'h0000_0000;

  // answer one cycle into the access phase; unmapped gives error
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      rd_q  <= 32'h0000_0000;
    end else begin
      rdy_q <= first;
      err_q <= first && !hit;
      if (first && !PWRITE) rd_q <= rdat;
    end
  end

  // configuration writes
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      for (int i = 0; i < PG_NPIN; i++) cfg_q[i] <= PG_CFG_RST;
      ctrl_q  <= PG_CTRL_RST;
      ensrc_q <= 16'h0000;
      vssrc_q <= 16'h0000;
    end else if (wr) begin
      if (a_cfg) cfg_q[a_idx] <= {PWDATA[10:8], 1'b0, PWDATA[6:0]};
      if (a == PG_OFS_CTRL) ctrl_q <= PWDATA[6:0];
      if (a == PG_OFS_ENSRC) ensrc_q <= PWDATA[15:0];
      if (a == PG_OFS_VSSRC) vssrc_q <= PWDATA[15:0];
    end
  end

  // ---------------------------------------------------------------
  // per-pin decode and input filters
  // ---------------------------------------------------------------
  pg_pmode_t pm;
  assign pm = pg_pmode_t'(PWR_MODE);
  wire quiesc  = (pm == PG_PM_QUIESC);
  wire mode_on = quiesc || (pm == PG_PM_ACTIVE);
  wire tick    = (tcnt_q == 17'(TICK_CYCLES - 1));
  wire [3:0] deb_lim = pg_deb_ticks(ctrl_q[PG_CT_DEB +: 2]);
  // reset levels are not pin levels: no edges until the pipeline has settled
  wire armed   = (arm_q == PG_ARM_CYC);
  wire ck_on   = (SEQ_CLK_EN || ctrl_q[PG_CT_CKON])
                 && !(quiesc && ctrl_q[PG_CT_PAUS]);

  logic [4:0] gpi, alt, od, pp, inr, pol, mbit, wen, wsty, pull, det, act;
  logic [4:0] rise, fall, srcl;
  logic [2:0] osrc [PG_NPIN];

  for (genvar i = 0; i < PG_NPIN; i++) begin : g_pin
    assign gpi[i]  = cfg_q[i][PG_CF_FUNC +: 2] == PG_FN_GPI;
    assign alt[i]  = cfg_q[i][PG_CF_FUNC +: 2] == PG_FN_ALT;
    assign od[i]   = cfg_q[i][PG_CF_FUNC +: 2] == PG_FN_OD;
    assign pp[i]   = cfg_q[i][PG_CF_FUNC +: 2] == PG_FN_PP;
    assign inr[i]  = gpi[i] || alt[i];
    assign pol[i]  = cfg_q[i][PG_CF_POL];
    assign mbit[i] = cfg_q[i][PG_CF_MODE];
    assign wen[i]  = cfg_q[i][PG_CF_WEN];
    assign wsty[i] = cfg_q[i][PG_CF_WSTY];
    assign pull[i] = cfg_q[i][PG_CF_PULL];
    assign osrc[i] = cfg_q[i][PG_CF_OSRC +: 3];
    // two flops inside, debounce on mode bit for inputs
    pg_filter u_flt (
      .clk    (MCLK),
      .nrst   (NRST),
      .pin    (GPIO_IN[i]),
      .deb_on (inr[i] && mbit[i]),
      .tick   (tick),
      .limit  (deb_lim),
      .lvl    (lvl[i])
    );
    // edges only counted while detection is allowed
    assign det[i]  = mode_on && !(quiesc && ctrl_q[PG_CT_QOFF] && inr[i]);
    assign act[i]  = pol[i] ? lvl[i] : !lvl[i];
    assign rise[i] = det[i] && armed && act[i] && !act_q[i];
    assign fall[i] = det[i] && armed && !act[i] && act_q[i];
    // output source; forwarding only on pins 0,1,3
    assign srcl[i] =
      osrc[i][2]            ? ((i != 2 && i != 4) ? lvl[osrc[i][1:0]] : mbit[i]) :
      osrc[i] == PG_OS_SEQ   ? SEQ_OUT[i] :
      osrc[i] == PG_OS_CLK   ? c2_q && ck_on :
      osrc[i] == PG_OS_FAULT ? (!flt_q) ^ mbit[i] : mbit[i];
  end

  wire [4:0] grise = rise & gpi;
  wire [4:0] gfall = fall & gpi;
  // only input-role pins raise events; system enable assert also does
  wire [4:0] ev_set = grise | {alt[4] && rise[4], 4'h0};
  wire ev_clr_wr = wr && (a == PG_OFS_EVENT);
  wire [4:0] ev_d = (ev_q & ~(ev_clr_wr ? PWDATA[4:0] : 5'h00)) | ev_set;
  wire wake = |(gpi & wen & ((wsty & act & det) | (~wsty & rise)))
              || (alt[2] && wen[2] && rise[2])
              || (alt[4] && rise[4]);

  // ---------------------------------------------------------------
  // regulator bits: pin edges beat software, software beats sequencer
  // ---------------------------------------------------------------
  wire reg_wr = wr && (a == PG_OFS_REGBIT);
  always_comb begin
    en_d = en_q;
    ab_d = ab_q;
    for (int k = 0; k < PG_NREG; k++) begin
      if (pg_pick(ensrc_q[2*k +: 2], grise)) en_d[k] = 1'b1;
      else if (pg_pick(ensrc_q[2*k +: 2], gfall)) en_d[k] = 1'b0;
      else if (reg_wr) en_d[k] = PWDATA[k];
      else if (SEQ_WR && ensrc_q[2*k +: 2] == 2'h0) en_d[k] = SEQ_REG_EN[k];
      if (pg_pick(vssrc_q[2*k +: 2], grise)) ab_d[k] = 1'b1;
      else if (pg_pick(vssrc_q[2*k +: 2], gfall)) ab_d[k] = 1'b0;
      else if (reg_wr) ab_d[k] = PWDATA[8+k];
      else if (SEQ_WR && vssrc_q[2*k +: 2] == 2'h0) ab_d[k] = SEQ_REG_AB[k];
    end
  end

  // ---------------------------------------------------------------
  // state: edges, events, alternate functions, regulators
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      act_q   <= 5'h00;
      ev_q    <= 5'h00;
      pend_q  <= 1'b0;
      en_q    <= 8'h00;
      ab_q    <= 8'h00;
      sys_q   <= 1'b0;
      pwr_q   <= 1'b0;
      pd_q    <= 1'b0;
      wk_q    <= 1'b0;
      kclr_q  <= 1'b0;
      khold_q <= 1'b0;
      wait_q  <= 1'b0;
      arm_q   <= 3'h0;
    end else begin
      act_q   <= act;
      ev_q    <= ev_d;
      pend_q  <= |ev_d;
      en_q    <= en_d;
      ab_q    <= ab_d;
      if (alt[4] && rise[4]) sys_q <= 1'b1;
      else if (alt[4] && fall[4]) sys_q <= 1'b0;
      if (alt[2] && rise[2]) pwr_q <= 1'b1;
      else if (alt[2] && fall[2]) pwr_q <= 1'b0;
      pd_q    <= alt[4] && fall[4];
      wk_q    <= wake;
      kclr_q  <= alt[0] && rise[0];
      khold_q <= alt[0] && det[0] && act[0];
      wait_q  <= grise[3];
      if (!armed) arm_q <= arm_q + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers; off modes release every output enable, pulls and settings stay
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      out_q <= 5'h00;
      oe_q  <= 5'h00;
      pu_q  <= 5'h00;
      pd5_q <= 5'h00;
    end else begin
      out_q <= pp & srcl;
      oe_q  <= mode_on ? (pp | (od & ~srcl)) : 5'h00;
      pu_q  <= od & pull;
      pd5_q <= inr & pull;
    end
  end

  // ---------------------------------------------------------------
  // supply fault timer, slow clock sync, millisecond tick
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      v1_q   <= 1'b0;
      v2_q   <= 1'b0;
      c1_q   <= 1'b0;
      c2_q   <= 1'b0;
      fcnt_q <= 24'h00_0000;
      flt_q  <= 1'b0;
      tcnt_q <= 17'h0_0000;
    end else begin
      v1_q   <= VSYS_LOW;
      v2_q   <= v1_q;
      c1_q   <= SLOW_CLK_IN;
      c2_q   <= c1_q;
      // strictly more than the fault time before asserting
      if (!v2_q) fcnt_q <= 24'h00_0000;
      else if (fcnt_q <= 24'(FAULT_CYCLES)) fcnt_q <= fcnt_q + 24'h00_0001;
      flt_q  <= v2_q && (fcnt_q > 24'(FAULT_CYCLES));
      tcnt_q <= tick ? 17'h0_0000 : tcnt_q + 17'h0_0001;
    end
  end

  assign PRDATA      = rd_q;
  assign PREADY      = rdy_q;
  assign PSLVERR     = err_q;
  assign GPIO_OUT    = out_q;
  assign GPIO_OE     = oe_q;
  assign GPIO_PU     = pu_q;
  assign GPIO_PD     = pd5_q;
  assign REG_EN      = en_q;
  assign REG_AB      = ab_q;
  assign SYSTEM_ENABLE_INPUT_BIT  = sys_q;
  assign POWER_ENABLE_INPUT_BIT  = pwr_q;
  assign PWRDOWN_REQ = pd_q;
  assign WAKEUP_REQ  = wk_q;
  assign WDOG_CLR    = kclr_q;
  assign WDOG_HOLD   = khold_q;
  assign WAIT_EDGE   = wait_q;
  assign EVENT_PEND  = pend_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!NRST);

  sequence s_sys_on;
    alt[4] && rise[4];
  endsequence
  sequence s_sys_up;
    SYSTEM_ENABLE_INPUT_BIT && WAKEUP_REQ && EVENT_PEND;
  endsequence

  AST_SYS_ON: assert property (s_sys_on |=> s_sys_up)
    else $error("system enable assert missed bit, wakeup or event");
  AST_SYS_OFF: assert property (alt[4] && fall[4] |=> PWRDOWN_REQ && !SYSTEM_ENABLE_INPUT_BIT)
    else $error("system enable deassert missed power-down");
  AST_EVT_STICKY: assert property (|grise |=> (ev_q & $past(grise)) == $past(grise))
    else $error("input event not latched");
  AST_OFF_RELEASE: assert property (!mode_on |=> GPIO_OE == 5'h00)
    else $error("driver active outside working modes");
  AST_NO_EDGE_OFF: assert property (!mode_on |-> (rise | fall) == 5'h00)
    else $error("edge seen outside working modes");
  AST_OD_LOW: assert property (1'b1 |=> (GPIO_OUT & $past(od)) == 5'h00)
    else $error("open-drain pin drove high");
  AST_WDOG: assert property (alt[0] && rise[0] |=> WDOG_CLR ##1 !WDOG_CLR)
    else $error("watchdog kick pulse wrong");
  AST_REG_EN: assert property (grise[1] && ensrc_q[1:0] == 2'h1 |=> REG_EN[0])
    else $error("regulator enable not set by pin");
  AST_REG_AB: assert property (gfall[2] && vssrc_q[1:0] == 2'h2 |=> !REG_AB[0])
    else $error("voltage select not cleared by pin");
  AST_SEQ_LOCK: assert property (SEQ_WR && ensrc_q[1:0] != 2'h0 && !reg_wr
      && !grise[ensrc_q[1:0]] && !gfall[ensrc_q[1:0]] |=> $stable(REG_EN[0]))
    else $error("sequencer changed a pin-owned enable");
  AST_WAIT: assert property (gpi[3] && rise[3] |=> WAIT_EDGE)
    else $error("wait edge missed");
  AST_FAULT: assert property ($rose(flt_q) |-> $past(fcnt_q) > 24'(FAULT_CYCLES))
    else $error("fault asserted early");
endmodule : pg_top
`default_nettype wire

// ==== test/pg_board.sv ====
/*
  board model for the gpio port: drives the five pins and the slow clock.
  assumes the block's own pin driver wins over the board's drive.
*/
`timescale 1ns/1ps
`default_nettype none
module pg_board (
  input  wire logic       clk,
  input  wire logic [4:0] ext_v,
  input  wire logic [4:0] ext_en,
  input  wire logic [4:0] out,
  input  wire logic [4:0] oe,
  input  wire logic [4:0] pu,
  input  wire logic [4:0] pd,
  output logic      [4:0] pin,
  output logic            slow_clk
);
  // ---------------------------------------------------------------
  // wire levels
  // ---------------------------------------------------------------
  logic [4:0] last_q = 5'h00;
  // a line nobody drives and nothing pulls flips each cycle, never stale
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pin[i] = oe[i] ? out[i] : ext_en[i] ? ext_v[i] : pu[i] | (~pd[i] & ~last_q[i]);
    end
  end
  // last level seen on each line
  always @(posedge clk) begin
    last_q <= pin;
  end
  // sped-up slow clock, free running, unrelated to clk
  initial begin
    slow_clk = 1'b0;
    forever #77 slow_clk = ~slow_clk;
  end
endmodule : pg_board
`default_nettype wire

// ==== test/testbench.sv ====
/*
  self-checking bench for the gpio port block, apb tasks and pin stimulus.
  assumes the board model on the pins and one 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pg_pkg::*;
;
  logic        mclk, nrst, psel, pen, pwr, vsys, seq_wr, errv, tog_q, pready, pslverr, slck;
  logic        system_enable_input, power_enable_input, pd_req, wake, wd_clr, wd_hold, wait_e, ev, seq_ck;
  logic [11:0] paddr;
  logic [31:0] pwdata, rdv, prdata;
  logic [7:0]  seq_en, seq_ab, reg_en, reg_ab;
  logic [4:0]  ext_v, ext_en, seq_out, pin, g_out, g_oe, g_pu, g_pd;
  logic [1:0]  pmode;
  int          err_total = 0, total_checks = 0, n_wait = 0, n_wake = 0, n_pd = 0;
  int          n_clr = 0, n_tog = 0, b1, b2, b3;

  pg_top #(.FAULT_CYCLES(50), .TICK_CYCLES(4)) DUT (
    .MCLK(mclk), .NRST(nrst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .GPIO_IN(pin),
    .GPIO_OUT(g_out), .GPIO_OE(g_oe), .GPIO_PU(g_pu), .GPIO_PD(g_pd), .PWR_MODE(pmode),
    .SLOW_CLK_IN(slck), .VSYS_LOW(vsys), .SEQ_CLK_EN(seq_ck), .SEQ_OUT(seq_out),
    .SEQ_WR(seq_wr), .SEQ_REG_EN(seq_en), .SEQ_REG_AB(seq_ab), .REG_EN(reg_en),
    .REG_AB(reg_ab), .SYSTEM_ENABLE_INPUT_BIT(system_enable_input), .POWER_ENABLE_INPUT_BIT(power_enable_input), .PWRDOWN_REQ(pd_req),
    .WAKEUP_REQ(wake), .WDOG_CLR(wd_clr), .WDOG_HOLD(wd_hold), .WAIT_EDGE(wait_e),
    .EVENT_PEND(ev)
  );
  pg_board board (.clk(mclk), .ext_v(ext_v), .ext_en(ext_en), .out(g_out), .oe(g_oe),
    .pu(g_pu), .pd(g_pd), .pin(pin), .slow_clk(slck));

  // ---------------------------------------------------------------
  // clock, pulse counters and tasks
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // one-cycle pulses are counted at every rising edge so none slips past a check
  always @(posedge mclk) begin
    n_wait += int'(wait_e === 1'b1);
    n_wake += int'(wake === 1'b1);
    n_pd += int'(pd_req === 1'b1);
    n_clr += int'(wd_clr === 1'b1);
    n_tog += int'(g_out[4] !== tog_q);
    tog_q = g_out[4];
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge mclk);
    pen <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0000);
    chk(rdv[15:0], e);
  endtask : rdc
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  // a hang costs one mismatch and ends the run the normal way
  initial begin
    #200000;
    err_total++;
    $display("mismatch at %0t: watchdog timeout", $time);
    final_report();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    {psel, pen, pwr, vsys, seq_wr, seq_ck} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {seq_en, seq_ab} = 16'h0000;
    seq_out = 5'h00;
    ext_v = 5'h15;
    ext_en = 5'h17;
    pmode = 2'b01;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rdc(PG_OFS_CFG0, 16'h0000);
    rdc(PG_OFS_CTRL, 16'h0000);
    apb(1'b0, 12'h100, 16'h0000);
    chk(16'(errv), 16'h0001);
    // output roles, pulls
    wr(12'h004, 16'h000B);
    wr(12'h00C, 16'h0042);
    wr(12'h008, 16'h0045);
    wt(4);
    chk(16'({g_oe, g_out}), 16'h0142);
    chk(16'({g_pu, g_pd}), 16'h0104);
    wr(12'h00C, 16'h004A);
    wt(4);
    chk(16'({g_oe, pin[3]}), 16'h0005);
    // regulator control from pin 1
    wr(12'h004, 16'h0005);
    wr(PG_OFS_ENSRC, 16'h0001);
    wr(PG_OFS_VSSRC, 16'h0004);
    wr(PG_OFS_EVENT, 16'h001F);
    ext_v[1] <= 1'b1;
    wt(8);
    chk(16'({reg_ab, reg_en}), 16'h0201);
    rdc(PG_OFS_EVENT, 16'h0002);
    seq_en <= 8'hFE;
    seq_wr <= 1'b1;
    wt(1);
    seq_wr <= 1'b0;
    wt(2);
    chk(16'({reg_ab, reg_en}), 16'h02FF);
    wr(PG_OFS_REGBIT, 16'h0000);
    wr(PG_OFS_EVENT, 16'h0002);
    wt(2);
    chk({reg_ab, reg_en}, 16'h0000);
    chk(16'(ev), 16'h0000);
    wr(PG_OFS_REGBIT, 16'h0201);
    ext_v[1] <= 1'b0;
    wt(8);
    chk(16'({ev, reg_ab, reg_en[0]}), 16'h0000);
    // edge and level wakeup
    wr(12'h004, 16'h0015);
    b1 = n_wake;
    ext_v[1] <= 1'b1;
    wt(8);
    chk(16'(n_wake - b1), 16'h0001);
    wr(12'h004, 16'h0035);
    wt(6);
    chk(16'(wake), 16'h0001);
    ext_v[1] <= 1'b0;
    wt(8);
    chk(16'(wake), 16'h0000);
    // pin 3 active low, sequencer wait edge
    ext_en[3] <= 1'b1;
    ext_v[3] <= 1'b1;
    wr(12'h00C, 16'h0001);
    wr(PG_OFS_EVENT, 16'h001F);
    ext_v[3] <= 1'b0;
    wt(8);
    chk(16'(n_wait), 16'h0001);
    rdc(PG_OFS_EVENT, 16'h0008);
    // shared debounce, 10 ticks
    wr(PG_OFS_CTRL, 16'h0003);
    wr(12'h004, 16'h000D);
    wr(PG_OFS_EVENT, 16'h001F);
    ext_v[1] <= 1'b1;
    wt(6);
    ext_v[1] <= 1'b0;
    wt(60);
    chk(16'(ev), 16'h0000);
    ext_v[1] <= 1'b1;
    wt(60);
    rdc(PG_OFS_EVENT, 16'h0002);
    // alternate inputs, active low
    wr(12'h008, 16'h0010);
    wr(PG_OFS_EVENT, 16'h001F);
    b1 = n_wake;
    b2 = n_clr;
    b3 = n_pd;
    ext_v[0] <= 1'b0;
    ext_v[4] <= 1'b0;
    wt(8);
    ext_v[2] <= 1'b0;
    wt(8);
    chk(16'({wd_hold, power_enable_input, system_enable_input}), 16'h0007);
    chk(16'((n_clr - b2) * 256 + n_wake - b1), 16'h0102);
    rdc(PG_OFS_EVENT, 16'h0010);
    ext_v[4] <= 1'b1;
    wt(8);
    chk(16'({n_pd - b3, 7'h00, system_enable_input}), 16'h0100);
    // forwarding, sequencer source, supply fault
    wr(12'h000, 16'h0503);
    wr(12'h00C, 16'h0103);
    seq_out <= 5'h08;
    wt(60);
    chk(16'(g_out & 5'h09), 16'h0009);
    wr(12'h00C, 16'h0303);
    vsys <= 1'b1;
    wt(30);
    chk(16'(g_out[3]), 16'h0001);
    wt(40);
    chk(16'(g_out[3]), 16'h0000);
    wr(12'h00C, 16'h030B);
    wt(4);
    chk(16'(g_out[3]), 16'h0001);
    // slow clock role set once, run by bit then by sequencer, paused in quiescent
    wr(12'h010, 16'h0203);
    wr(PG_OFS_CTRL, 16'h0020);
    wt(20);
    b1 = n_tog;
    wt(100);
    chk(16'(n_tog - b1 > 4), 16'h0001);
    wr(PG_OFS_CTRL, 16'h0000);
    seq_ck <= 1'b1;
    wt(20);
    b1 = n_tog;
    wt(100);
    chk(16'(n_tog - b1 > 4), 16'h0001);
    wr(PG_OFS_CTRL, 16'h0070);
    pmode <= 2'b00;
    wr(PG_OFS_EVENT, 16'h001F);
    b1 = n_tog;
    ext_v[1] <= 1'b0;
    wt(100);
    // a detected fall of pin 1 would clear regulator 0, so it must stay set
    chk(16'({n_tog - b1, ev, reg_en[0], g_oe}), 16'h0039);
    // off mode releases every output enable and keeps pin settings
    pmode <= 2'b11;
    wt(4);
    chk(16'(g_oe), 16'h0000);
    rdc(12'h010, 16'h0203);
    pmode <= 2'b01;
    wt(4);
    chk(16'(g_oe), 16'h0019);
    final_report();
  end
endmodule : testbench
`default_nettype wire
